//--- verilog/rca_top.sv
// regulator housekeeping: reset hold, config load, strap address offset,
// conversion gating and output target selection
// assumes synchronous inputs, a config memory with one-cycle read latency,
// and an adc that pulses adc_done with a stable code
//
// Behaviour
// (R1) Internal reset holds until bias, core rail and oscillator are good.
// (R2) Leaving reset, every config memory entry is copied to working regs.
// (R3) After the load, bus writes change working regs regardless of enable.
// (R4) Conversion runs only with enable, input voltage, load and strap done.
// (R5) Separate 7-bit base addresses are kept for I2C and PMBus.
// (R6) An I2C base of zero disables I2C responses only.
// (R7) A PMBus base of zero disables PMBus responses only.
// (R8) Effective address is base plus strap offset, defaults 0x10 and 0x40.
// (R9) The strap is measured by the 10 bit adc into one of 16 offsets.
// (R10) Strap to offset is monotonic, lowest resistor +0, highest +15.
// (R11) With strap-ignore set both buses answer at their base addresses.
// (R12) In select-pin mode the target is the code in register 77h plus index.
// (R13) Outside select-pin mode the bus target is used, pins ignored.
// (R14) The code becomes millivolts by the 5 mV or the 10 mV step table.
// (R15) Register reads stay available in both voltage modes.
// (R16) Select pins form a 3-bit index, bit2 the most significant.
// (R17) Select pins are synchronised; in select-pin mode an index change starts a ramp.
`timescale 1ns/10ps
`default_nettype none
`include "rca_map.svh"

module rca_top (
    input wire logic clock,
    input wire logic rst,
    input wire rca_pkg::rca_supply_t supply,
    input wire logic enable_ok,
    input wire logic pvin_uv_ok,
    output logic por_hold,
    output logic mtp_rd_en,
    output logic [`RCA_IDX_W-1:0] mtp_addr,
    input wire logic [7:0] mtp_data,
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [9:0] adc_code,
    input wire rca_pkg::rca_cmd_t cmd,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output rca_pkg::rca_addr_t bus_addr,
    input wire logic volt_select_bit0,
    input wire logic volt_select_bit1,
    input wire logic volt_select_bit2,
    output rca_pkg::rca_vout_t vout,
    output logic conv_enable,
    output logic load_done,
    output logic strap_done
);
    import rca_pkg::*;

    rca_st_t st_r;
    rca_st_t st_nxt;
    logic [3:0] strap_offset;
    logic supplies_good;
    logic [7:0] ctrl;
    logic [2:0] sel_idx;
    logic [7:0] code_sel;
    logic [`RCA_IDX_W-1:0] vsel_reg;

    function automatic logic [11:0] code_to_mv(
        input logic [7:0] code,
        input logic step10
    );
        logic [11:0] steps;
        steps = {4'h0, code} - 12'h001;
        if (code == 8'h00)
        begin
            return 12'h000;
        end
        else if (step10)
        begin
            return `RCA_MV10_BASE + 12'(steps * `RCA_MV10_STEP);
        end
        else
        begin
            return `RCA_MV5_BASE + 12'(steps * `RCA_MV5_STEP);
        end
    endfunction : code_to_mv

    function automatic rca_addr_t make_addr(
        input logic [6:0] i2c_base,
        input logic [6:0] pm_base,
        input logic [3:0] off,
        input logic ignore,
        input logic ready
    );
        rca_addr_t a;
        logic [6:0] add;
        add = ignore ? 7'h00 : {3'h0, off}; // (R11)
        a.i2c_addr = i2c_base + add; // (R8)
        a.pmbus_addr = pm_base + add; // (R8)
        a.i2c_en = ready && (i2c_base != 7'h00); // (R6)
        a.pmbus_en = ready && (pm_base != 7'h00); // (R7)
        return a;
    endfunction : make_addr

    rca_strap_decode u_strap (
        .adc_code(adc_code),
        .offset(strap_offset)
    );

    assign supplies_good = supply.bias_ok && supply.core_rail_monitor
        && supply.osc_stable;
    assign ctrl = st_r.work[`RCA_REG_CTRL];
    // index bit2 is the most significant pin
    assign sel_idx = st_r.sel_sync; // (R16)
    assign vsel_reg = `RCA_REG_VSEL_BASE + {4'h0, sel_idx}; // (R16)
    assign code_sel = ctrl[`RCA_CTRL_PVSEL_MODE]
        ? st_r.work[vsel_reg] // (R12)
        : st_r.work[`RCA_REG_VOUT]; // (R13)

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.adc_req = 1'b0;
        st_nxt.rd_valid = 1'b0;
        st_nxt.vout.ramp_start = 1'b0;

        // select pin synchroniser
        st_nxt.sel_meta = {volt_select_bit2, volt_select_bit1,
            volt_select_bit0}; // (R17)
        st_nxt.sel_sync = st_r.sel_meta; // (R17)
        st_nxt.sel_prev = st_r.sel_sync;

        // load pipeline: data of last request lands this cycle
        st_nxt.ld_pend = 1'b0;
        if (st_r.ld_pend)
        begin
            st_nxt.work[st_r.ld_pend_addr] = mtp_data; // (R2)
        end

        unique case (st_r.state)
            RCA_ST_POR:
            begin
                st_nxt.ld_idx = 8'h00;
                st_nxt.load_done = 1'b0;
                st_nxt.strap_done = 1'b0;
                if (supplies_good) // (R1)
                begin
                    st_nxt.state = RCA_ST_LOAD;
                end
            end
            RCA_ST_LOAD:
            begin
                if (st_r.ld_idx < 8'(`RCA_CFG_DEPTH))
                begin
                    st_nxt.ld_pend = 1'b1; // (R2)
                    st_nxt.ld_pend_addr = st_r.ld_idx[`RCA_IDX_W-1:0];
                    st_nxt.ld_idx = st_r.ld_idx + 8'h01;
                end
                else if (!st_r.ld_pend)
                begin
                    st_nxt.load_done = 1'b1; // (R2)
                    st_nxt.adc_req = 1'b1; // (R9)
                    st_nxt.state = RCA_ST_STRAP;
                end
            end
            RCA_ST_STRAP:
            begin
                if (adc_done)
                begin
                    st_nxt.offset = strap_offset; // (R9)
                    st_nxt.strap_done = 1'b1;
                    st_nxt.state = RCA_ST_READY;
                end
            end
            RCA_ST_READY:
            begin
                st_nxt.state = RCA_ST_READY;
            end
        endcase

        // supply loss returns to reset from any state
        if (!supplies_good) // (R1)
        begin
            st_nxt.state = RCA_ST_POR;
            st_nxt.ld_pend = 1'b0;
        end

        // bus writes, only once the load is over, enable not consulted
        if (cmd.wr && st_r.load_done && !cmd.addr[7]) // (R3)
        begin
            st_nxt.work[cmd.addr[`RCA_IDX_W-1:0]] = cmd.wdata; // (R3)
        end

        // reads serve in every voltage mode
        if (cmd.rd) // (R15)
        begin
            st_nxt.rd_valid = 1'b1;
            if (!cmd.addr[7])
            begin
                st_nxt.rd_data = st_r.work[cmd.addr[`RCA_IDX_W-1:0]];
            end
            else if (cmd.addr == `RCA_REG_STATUS)
            begin
                st_nxt.rd_data = {st_r.conv_en, st_r.strap_done,
                    st_r.load_done, sel_idx[0], st_r.offset};
            end
            else if (cmd.addr == `RCA_REG_EFF_I2C)
            begin
                st_nxt.rd_data = {st_r.addr.i2c_en, st_r.addr.i2c_addr};
            end
            else if (cmd.addr == `RCA_REG_EFF_PMBUS)
            begin
                st_nxt.rd_data = {st_r.addr.pmbus_en,
                    st_r.addr.pmbus_addr};
            end
            else
            begin
                st_nxt.rd_data = 8'h00;
            end
        end

        // effective addresses
        st_nxt.addr = make_addr(
            st_r.work[`RCA_REG_I2C_BASE][6:0], // (R5)
            st_r.work[`RCA_REG_PMBUS_BASE][6:0], // (R5)
            st_r.offset,
            ctrl[`RCA_CTRL_STRAP_IGNORE],
            st_r.strap_done);

        // conversion gate
        st_nxt.conv_en = enable_ok && pvin_uv_ok && st_r.load_done
            && st_r.strap_done && (st_r.state == RCA_ST_READY); // (R4)

        // output target and ramp trigger
        st_nxt.vout.code = code_sel;
        st_nxt.vout.mv = code_to_mv(code_sel,
            ctrl[`RCA_CTRL_STEP10]); // (R14)
        if (st_r.state == RCA_ST_READY)
        begin
            if (code_sel != st_r.vout.code)
            begin
                st_nxt.vout.ramp_start = 1'b1;
            end
            if (ctrl[`RCA_CTRL_PVSEL_MODE]
                && (st_r.sel_sync != st_r.sel_prev)) // (R17)
            begin
                st_nxt.vout.ramp_start = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.state <= RCA_ST_POR;
            st_r.work[`RCA_REG_I2C_BASE] <= {1'b0, `RCA_I2C_BASE_RST};
            st_r.work[`RCA_REG_PMBUS_BASE] <= {1'b0, `RCA_PMBUS_BASE_RST};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign por_hold = (st_r.state == RCA_ST_POR); // (R1)
    assign mtp_rd_en = (st_r.state == RCA_ST_LOAD)
        && (st_r.ld_idx < 8'(`RCA_CFG_DEPTH));
    assign mtp_addr = st_r.ld_idx[`RCA_IDX_W-1:0];
    assign adc_start = st_r.adc_req;
    assign rd_data = st_r.rd_data;
    assign rd_valid = st_r.rd_valid;
    assign bus_addr = st_r.addr;
    assign vout = st_r.vout;
    assign conv_enable = st_r.conv_en;
    assign load_done = st_r.load_done;
    assign strap_done = st_r.strap_done;

endmodule : rca_top

`default_nettype wire

//--- verilog/rca_map.svh
// offsets, field positions, reset values and conversion constants
// assumes inclusion by the package and the design files by bare name
`ifndef RCA_MAP_SVH
`define RCA_MAP_SVH

// working register array
`define RCA_CFG_DEPTH 128
`define RCA_IDX_W 7

// working register offsets (command codes)
`define RCA_REG_I2C_BASE 7'h00
`define RCA_REG_PMBUS_BASE 7'h01
`define RCA_REG_CTRL 7'h02
`define RCA_REG_VOUT 7'h03
`define RCA_REG_VSEL_BASE 7'h77

// read-only status, above the array
`define RCA_REG_STATUS 8'h80
`define RCA_REG_EFF_I2C 8'h81
`define RCA_REG_EFF_PMBUS 8'h82

// control register fields
`define RCA_CTRL_STRAP_IGNORE 0
`define RCA_CTRL_PVSEL_MODE 1
`define RCA_CTRL_STEP10 2

// reset values of the base addresses
`define RCA_I2C_BASE_RST 7'h10
`define RCA_PMBUS_BASE_RST 7'h40

// code to millivolt conversion
`define RCA_MV5_BASE 12'h0FA
`define RCA_MV5_STEP 12'h005
`define RCA_MV10_BASE 12'h1F4
`define RCA_MV10_STEP 12'h00A

`endif

//--- verilog/rca_pkg.sv
// types shared by the configuration loader and its strap decoder
// assumes rca_map.svh on the include path
`include "rca_map.svh"

package rca_pkg;

    typedef enum logic [3:0] {
        RCA_ST_POR   = 4'b0001,
        RCA_ST_LOAD  = 4'b0010,
        RCA_ST_STRAP = 4'b0100,
        RCA_ST_READY = 4'b1000
    } rca_state_t;

    typedef struct packed {
        logic bias_ok;
        logic core_rail_monitor;
        logic osc_stable;
    } rca_supply_t;

    typedef struct packed {
        logic i2c_en;
        logic [6:0] i2c_addr;
        logic pmbus_en;
        logic [6:0] pmbus_addr;
    } rca_addr_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rca_cmd_t;

    typedef struct packed {
        logic [7:0] code;
        logic [11:0] mv;
        logic ramp_start;
    } rca_vout_t;

    typedef struct packed {
        rca_state_t state;
        logic [7:0] ld_idx;
        logic ld_pend;
        logic [`RCA_IDX_W-1:0] ld_pend_addr;
        logic load_done;
        logic strap_done;
        logic adc_req;
        logic [3:0] offset;
        logic [2:0] sel_meta;
        logic [2:0] sel_sync;
        logic [2:0] sel_prev;
        rca_vout_t vout;
        logic conv_en;
        rca_addr_t addr;
        logic [7:0] rd_data;
        logic rd_valid;
        logic [`RCA_CFG_DEPTH-1:0][7:0] work;
    } rca_st_t;

endpackage : rca_pkg

//--- verilog/rca_strap_decode.sv
// strap decoder: 10 bit adc code to one of 16 address offsets
// assumes a settled adc code; purely combinational
`timescale 1ns/10ps
`default_nettype none

module rca_strap_decode #(
    parameter logic [14:0][9:0] BAND_EDGE = {
        10'h384, 10'h332, 10'h2E9, 10'h29E, 10'h252, 10'h209, 10'h1C3,
        10'h186, 10'h14E, 10'h11B, 10'h0EA, 10'h0BA, 10'h090, 10'h068,
        10'h03E}
)(
    input wire logic [9:0] adc_code,
    output logic [3:0] offset
);
    import rca_pkg::*;

    logic [14:0] above;

    function automatic logic [3:0] count_ones(input logic [14:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 15; i++)
        begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : count_ones

    // one comparator per band edge, count edges passed
    for (genvar g = 0; g < 15; g++)
    begin : g_edge
        assign above[g] = (adc_code >= BAND_EDGE[g]); // (R10)
    end

    assign offset = count_ones(above); // (R9)

endmodule : rca_strap_decode

`default_nettype wire

//--- dv/rca_top_props.sv
// assertions on the loader's top-level ports
// assumes bind into rca_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
`include "rca_map.svh"

module rca_top_props (
    input wire logic clock,
    input wire logic rst,
    input wire rca_pkg::rca_supply_t supply,
    input wire logic enable_ok,
    input wire logic pvin_uv_ok,
    input wire logic por_hold,
    input wire logic mtp_rd_en,
    input wire logic [`RCA_IDX_W-1:0] mtp_addr,
    input wire logic adc_done,
    input wire rca_pkg::rca_cmd_t cmd,
    input wire logic rd_valid,
    input wire rca_pkg::rca_addr_t bus_addr,
    input wire rca_pkg::rca_vout_t vout,
    input wire logic conv_enable,
    input wire logic load_done,
    input wire logic strap_done
);
    import rca_pkg::*;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    hold_in_por_a: assert property (supply != 3'b111 |=> por_hold)
        else $error("reset released with a supply bad");
    load_step_a: assert property (mtp_rd_en && mtp_addr != 7'h7F
        && supply == 3'b111 |=> mtp_rd_en
        && mtp_addr == $past(mtp_addr) + 7'h01)
        else $error("load address sequence broken");
    load_end_a: assert property ((mtp_rd_en && mtp_addr == 7'h7F
        && supply == 3'b111) ##1 supply == 3'b111 ##1 1'b1 |=> load_done)
        else $error("load not done after last address");
    strap_take_a: assert property (adc_done && load_done && !strap_done
        && !por_hold && supply == 3'b111 |=> strap_done)
        else $error("strap result not taken");
    addr_gate_a: assert property (bus_addr.i2c_en || bus_addr.pmbus_en
        |-> $past(strap_done))
        else $error("address enabled before strap read");
    conv_off_a: assert property (conv_enable
        |-> $past(enable_ok && pvin_uv_ok && load_done && strap_done))
        else $error("conversion without all conditions");
    conv_on_a: assert property (enable_ok && pvin_uv_ok && load_done
        && strap_done && !por_hold |=> conv_enable)
        else $error("conversion not enabled");
    rd_reply_a: assert property (rd_valid == $past(cmd.rd))
        else $error("read reply missing or spurious");
    ramp_kick_a: assert property ($changed(vout.code)
        && $past(strap_done) |-> ##[0:1] vout.ramp_start)
        else $error("target change without ramp");
    mv_table_a: assert property (vout.code != 8'h00 |->
        vout.mv == 12'h0FA + (12'(vout.code) - 12'h001) * 12'h005
        || vout.mv == 12'h1F4 + (12'(vout.code) - 12'h001) * 12'h00A)
        else $error("millivolt value off both tables");
endmodule : rca_top_props

bind rca_top rca_top_props i_props (.clock(clock), .rst(rst), .supply(supply),
    .enable_ok(enable_ok), .pvin_uv_ok(pvin_uv_ok), .por_hold(por_hold),
    .mtp_rd_en(mtp_rd_en), .mtp_addr(mtp_addr), .adc_done(adc_done),
    .cmd(cmd), .rd_valid(rd_valid), .bus_addr(bus_addr), .vout(vout),
    .conv_enable(conv_enable), .load_done(load_done),
    .strap_done(strap_done));

`default_nettype wire

//--- dv/rca_far_model.sv
// far side model: config memory and strap adc
// assumes the loader's clock; data held one cycle only
`timescale 1ns/10ps
`default_nettype none

module rca_far_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic mtp_rd_en,
    input wire logic [6:0] mtp_addr,
    output logic [7:0] mtp_data,
    input wire logic adc_start,
    input wire logic [4:0] adc_lag,
    input wire logic [9:0] strap_code,
    output logic adc_done,
    output logic [9:0] adc_code
);
    logic [4:0] cnt;

    function automatic logic [7:0] mem_val(input logic [6:0] k);
        case (k)
            7'h00: return 8'h10;
            7'h01: return 8'h40;
            7'h02: return 8'h00;
            7'h03: return 8'h20;
            default: return {1'b0, k} + 8'h11;
        endcase
    endfunction : mem_val

    // stale data is scrambled so a late sample shows
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            mtp_data <= 8'h00;
            adc_done <= 1'b0;
            adc_code <= 10'h000;
            cnt <= 5'h00;
        end
        else
        begin
            mtp_data <= mtp_rd_en ? mem_val(mtp_addr) : ~mtp_data;
            adc_done <= (cnt == 5'h01);
            adc_code <= (cnt == 5'h01) ? strap_code : ~adc_code;
            cnt <= adc_start ? adc_lag : (cnt != 5'h00 ? cnt - 5'h01 : 5'h00);
        end
    end
endmodule : rca_far_model

`default_nettype wire

//--- dv/testbench.sv
// testbench for the regulator housekeeping loader
// assumes rca_top, the far side model and the bound checker
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import rca_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    rca_supply_t supply = 3'b000;
    logic enable_ok = 1'b0;
    logic pvin_uv_ok = 1'b0;
    rca_cmd_t cmd = '0;
    logic volt_select_bit0 = 1'b0;
    logic volt_select_bit1 = 1'b0;
    logic volt_select_bit2 = 1'b0;
    logic [4:0] adc_lag = 5'h01;
    logic [9:0] strap_code = 10'h000;
    logic por_hold, mtp_rd_en, adc_start, adc_done, rd_valid;
    logic conv_enable, load_done, strap_done;
    logic [6:0] mtp_addr;
    logic [7:0] mtp_data, rd_data;
    logic [9:0] adc_code;
    rca_addr_t bus_addr;
    rca_vout_t vout;
    int n_fail = 0;
    int tests_run = 0;
    int n_ramp = 0;
    int ramp_mark = 0;
    localparam logic [9:0] CODES [5] = '{10'h3FF, 10'h000, 10'h03E, 10'h383,
        10'h090};
    localparam logic [3:0] OFFS [5] = '{4'hF, 4'h0, 4'h1, 4'hE, 4'h3};

    always #5 clock = ~clock;

    always @(negedge clock)
        if (vout.ramp_start === 1'b1)
            n_ramp++;

    rca_top i_dut (.clock(clock), .rst(rst), .supply(supply),
        .enable_ok(enable_ok), .pvin_uv_ok(pvin_uv_ok), .por_hold(por_hold),
        .mtp_rd_en(mtp_rd_en), .mtp_addr(mtp_addr), .mtp_data(mtp_data),
        .adc_start(adc_start), .adc_done(adc_done), .adc_code(adc_code),
        .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid),
        .bus_addr(bus_addr), .volt_select_bit0(volt_select_bit0),
        .volt_select_bit1(volt_select_bit1),
        .volt_select_bit2(volt_select_bit2), .vout(vout),
        .conv_enable(conv_enable), .load_done(load_done),
        .strap_done(strap_done));

    rca_far_model i_far (.clock(clock), .rst(rst), .mtp_rd_en(mtp_rd_en),
        .mtp_addr(mtp_addr), .mtp_data(mtp_data), .adc_start(adc_start),
        .adc_lag(adc_lag), .strap_code(strap_code), .adc_done(adc_done),
        .adc_code(adc_code));

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
        input string what);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        cmd <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        cmd <= '0;
        repeat (3) @(posedge clock);
    endtask : bus_wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        cmd <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        cmd <= '0;
        #1;
        check({8'h00, rd_data}, {8'h00, exp}, "read data");
    endtask : rd_chk

    task automatic init(input logic [9:0] code, input logic [4:0] lag,
        input logic [3:0] off);
        int j;
        @(posedge clock);
        supply <= 3'b000;
        strap_code <= code;
        adc_lag <= lag;
        repeat (3) @(posedge clock);
        #1;
        check({15'h0, por_hold}, 16'h0001, "reset hold");
        check({15'h0, load_done}, 16'h0000, "load done");
        @(posedge clock);
        supply <= 3'b111;
        for (j = 0; j < 400 && strap_done !== 1'b1; j++)
            @(negedge clock);
        @(posedge clock);
        #1;
        check({15'h0, load_done}, 16'h0001, "load done");
        check(bus_addr, {1'b1, 7'h10 + 7'(off), 1'b1, 7'h40 + 7'(off)},
            "bus address");
    endtask : init

    task automatic look(input logic [15:0] seen, input logic [15:0] exp);
        #1;
        check(seen, exp, "port value");
    endtask : look

    initial
    begin
        repeat (2000) @(posedge clock);
        n_fail++;
        final_report();
    end

    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
            init(CODES[i], 5'(i * 7 + 1), OFFS[i]);
        for (int k = 0; k < 128; k++)
            rd_chk(8'(k), i_far.mem_val(7'(k)));
        rd_chk(8'h90, 8'h00);
        rd_chk(8'h80, 8'h63);
        rd_chk(8'h81, 8'h93);
        rd_chk(8'h82, 8'hC3);
        look({8'h00, vout.code}, 16'h0020);
        look({4'h0, vout.mv}, 16'h0195);
        @(posedge clock);
        {volt_select_bit2, volt_select_bit1, volt_select_bit0} <= 3'b101;
        bus_wr(8'h02, 8'h04);
        look({8'h00, vout.code}, 16'h0020);
        look({4'h0, vout.mv}, 16'h032A);
        bus_wr(8'h02, 8'h06);
        ramp_mark = n_ramp;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clock);
            {volt_select_bit2, volt_select_bit1, volt_select_bit0} <= 3'(i);
            repeat (5) @(posedge clock);
            look({8'h00, vout.code},
                {8'h00, i_far.mem_val(7'h77 + 7'(i))});
            rd_chk(8'h03, 8'h20);
        end
        check(16'(n_ramp - ramp_mark), 16'h0008, "ramp count");
        bus_wr(8'h7D, 8'h8F);
        ramp_mark = n_ramp;
        @(posedge clock);
        {volt_select_bit2, volt_select_bit1, volt_select_bit0} <= 3'b110;
        repeat (5) @(posedge clock);
        look({8'h00, vout.code}, 16'h008F);
        check(16'(n_ramp - ramp_mark), 16'h0001, "index ramp");
        bus_wr(8'h02, 8'h01);
        look(bus_addr, 16'h90C0);
        bus_wr(8'h00, 8'h00);
        look(bus_addr, 16'h00C0);
        bus_wr(8'h00, 8'h10);
        bus_wr(8'h01, 8'h00);
        look(bus_addr, 16'h9000);
        rd_chk(8'h00, 8'h10);
        @(posedge clock);
        enable_ok <= 1'b1;
        repeat (3) @(posedge clock);
        look({15'h0, conv_enable}, 16'h0000);
        @(posedge clock);
        pvin_uv_ok <= 1'b1;
        repeat (2) @(posedge clock);
        look({15'h0, conv_enable}, 16'h0001);
        @(posedge clock);
        pvin_uv_ok <= 1'b0;
        repeat (2) @(posedge clock);
        look({15'h0, conv_enable}, 16'h0000);
        bus_wr(8'h03, 8'h30);
        rd_chk(8'h03, 8'h30);
        look({8'h00, vout.code}, 16'h0030);
        final_report();
    end
endmodule : testbench

`default_nettype wire
